// file: ndio_blink.v
// Blink enable divider for the health indicators
`timescale 1ns/1ps
module ndio_blink #(
    parameter integer HALF_CYCLES = 62500000
) (
    input wire clk,
    input wire sys_rst,
    output reg blink_ff
);
    // Cycle counter for half a blink period
    reg [31:0] cnt_ff;
    wire [31:0] nxt_cnt = cnt_ff + 32'h00000001;

    // Toggle the blink level each half period
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff <= 32'h00000000;
            blink_ff <= 1'b0;
        end else if (nxt_cnt >= HALF_CYCLES[31:0]) begin
            cnt_ff <= 32'h00000000;
            blink_ff <= ~blink_ff;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // ndio_blink

// file: ndio_ctrl_model.sv
// Controller model driving the consumed side
`timescale 1ns/1ps
module ndio_ctrl_model (
    input wire clk,
    output logic [119:0] con_image,
    output logic con_valid,
    output logic ctrl_stopped,
    output logic comm_lost,
    output logic diag_clear
);
    // Idle and running after power-up
    initial {con_image, con_valid, ctrl_stopped, comm_lost, diag_clear} = 124'h0;
    // stale image inverted so it cannot be reused
    task automatic send(input logic [119:0] img);
        @(negedge clk) {con_image, con_valid} = {img, 1'b1};
        @(negedge clk) {con_image, con_valid} = {~img, 1'b0};
    endtask
    // Stop, link loss and clear request
    task automatic state(input logic [2:0] s);
        @(negedge clk) {ctrl_stopped, comm_lost, diag_clear} = s;
    endtask
endmodule // ndio_ctrl_model

// file: ndio_image.v
// Discrete I/O image logic: consumed/produced images and indicators
// How it works
// - Outputs follow consumed image bits one to eight
// - Hold-select bit per output chooses hold
// - Stopped controller with hold zero applies override
// - Consumed bit 80 sets input polarity
// - Input states fill produced bits one to eight
// - Produced bit 9 flags faults outputs 1-4
// - Produced bit 10 flags faults outputs 5-8
// - Diagnosis word in 33-48, version and class in 49-64, reserved 11-32
// - Produced image broadcast to all controllers
// - Node identifier valid from 01 to FD
// - Link runs at fixed 125 kbaud
// - Module indicator shows self-test and run state
// - Network indicator shows link health state
// - Point indicator lit while point is ON
// - Communication loss applies hold or override like a stop, sets life error
// - Produced data sent on input change
`timescale 1ns/1ps
`include "ndio_regs.vh"
module ndio_image #(
    parameter integer NPTS = 8,
    // Firmware version value is arbitrary
    parameter [7:0] FW_VERSION = 8'h01,
    // Device class value is arbitrary
    parameter [7:0] DEV_CLASS = 8'h5A,
    parameter integer BLINK_HALF = (`NDIO_CLK_HZ / 1000) * `NDIO_BLINK_MS
) (
    input wire clk,
    input wire sys_rst,
    input wire [`NDIO_CON_WIDTH-1:0] con_image,
    input wire con_valid,
    input wire ctrl_stopped,
    input wire comm_lost,
    input wire diag_clear,
    input wire [NPTS-1:0] raw_inputs,
    input wire [NPTS-1:0] out_fault,
    input wire solid_state,
    input wire [7:0] node_id,
    input wire mem_test_fail,
    input wire io_test_fail,
    input wire powerup_busy,
    input wire ack_dup_fail,
    output reg [NPTS-1:0] dout_ff,
    output reg [`NDIO_PRO_WIDTH-1:0] pro_image_ff,
    output reg pro_send_ff,
    output wire pro_broadcast,
    output wire id_valid,
    output wire [31:0] baud_rate,
    output reg [1:0] module_health_indicator,
    output reg [1:0] network_health_indicator,
    output wire [NPTS-1:0] in_led,
    output wire [NPTS-1:0] out_led
);
    // Indicator colour codes: bit1 red, bit0 green
    localparam [1:0] LED_OFF = 2'h0;
    localparam [1:0] LED_GRN = 2'h1;
    localparam [1:0] LED_RED = 2'h2;

    // Latched configuration from the consumed image, plus diagnosis flags and previous inputs
    reg [NPTS-1:0] hold_ff;
    reg [NPTS-1:0] ovr_ff;
    reg neg_pol_ff;
    reg [NPTS-1:0] cmd_ff;
    reg life_err_ff;
    reg pup_err_ff;
    reg [NPTS-1:0] prev_in_ff;
    wire blink;
    wire [NPTS-1:0] in_state;
    wire [15:0] diag_word;
    reg [NPTS-1:0] nxt_dout;
    integer i;

    // Shared blink phase so both indicators flash in step
    ndio_blink #(.HALF_CYCLES(BLINK_HALF)) ndio_blink_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .blink_ff(blink)
    );

    assign id_valid = (node_id >= `NDIO_ID_MIN) && (node_id <= `NDIO_ID_MAX);
    assign baud_rate = `NDIO_BAUD;
    assign pro_broadcast = 1'b1;
    assign in_state = neg_pol_ff ? ~raw_inputs : raw_inputs;
    assign in_led = in_state;
    assign out_led = dout_ff;

    // Status word: only life and power-up bits defined
    assign diag_word = {5'h00, pup_err_ff, life_err_ff, 9'h000};

    // Capture consumed image; reserved bits never looked at
    always @(posedge clk) begin
        if (sys_rst) begin
            cmd_ff <= {NPTS{1'b0}};
            hold_ff <= {NPTS{1'b0}};
            ovr_ff <= {NPTS{1'b0}};
            neg_pol_ff <= 1'b0;
        end else if (con_valid) begin
            cmd_ff <= con_image[`NDIO_CON_OUT_LSB +: NPTS];
            hold_ff <= con_image[`NDIO_CON_HOLD_LSB +: NPTS];
            ovr_ff <= con_image[`NDIO_CON_OVR_LSB +: NPTS];
            neg_pol_ff <= con_image[`NDIO_CON_POL_BIT];
        end
    end

    // Output select per channel
    always @* begin
        nxt_dout = dout_ff;
        for (i = 0; i < NPTS; i = i + 1) begin
            if (comm_lost || ctrl_stopped) begin
                if (hold_ff[i]) begin
                    nxt_dout[i] = dout_ff[i];
                end else begin
                    nxt_dout[i] = ovr_ff[i];
                end
            end else begin
                nxt_dout[i] = cmd_ff[i];
            end
        end
    end

    // Output register
    always @(posedge clk) begin
        if (sys_rst) begin
            dout_ff <= {NPTS{1'b0}};
        end else begin
            dout_ff <= nxt_dout;
        end
    end

    // Sticky diagnosis flags; set wins over clear
    always @(posedge clk) begin
        if (sys_rst) begin
            life_err_ff <= 1'b0;
            pup_err_ff <= 1'b1;
        end else begin
            life_err_ff <= comm_lost | (life_err_ff & ~diag_clear);
            // Power-up flag cleared only by controller
            pup_err_ff <= pup_err_ff & ~diag_clear;
        end
    end

    // Produced image and change-of-state send
    always @(posedge clk) begin
        if (sys_rst) begin
            pro_image_ff <= {`NDIO_PRO_WIDTH{1'b0}};
            prev_in_ff <= {NPTS{1'b0}};
            pro_send_ff <= 1'b0;
        end else begin
            pro_image_ff <= {`NDIO_PRO_WIDTH{1'b0}};
            pro_image_ff[`NDIO_PRO_IN_LSB +: NPTS] <= in_state;
            pro_image_ff[`NDIO_PRO_FLT_LO_BIT] <= solid_state & (|out_fault[3:0]);
            pro_image_ff[`NDIO_PRO_FLT_HI_BIT] <= solid_state & (|out_fault[7:4]);
            pro_image_ff[`NDIO_PRO_DIAG_LSB +: 16] <= diag_word;
            pro_image_ff[`NDIO_PRO_FW_LSB +: 8] <= FW_VERSION;
            pro_image_ff[`NDIO_PRO_CLASS_LSB +: 8] <= DEV_CLASS;
            prev_in_ff <= in_state;
            pro_send_ff <= (in_state != prev_in_ff);
        end
    end

    // Blink decode: colour on the lit half, dark on the other
    function [1:0] ndio_flash;
        input phase;
        input [1:0] colour;
        begin
            ndio_flash = phase ? colour : LED_OFF;
        end
    endfunction

    // Indicator states; failures outrank the run states
    always @(posedge clk) begin
        if (sys_rst) begin
            // Dark while reset holds
            module_health_indicator <= LED_OFF;
            network_health_indicator <= LED_OFF;
        end else begin
            if (mem_test_fail) begin
                // Memory self-test failed, solid red
                module_health_indicator <= LED_RED;
            end else if (io_test_fail) begin
                // I/O test failed, blinking red
                module_health_indicator <= ndio_flash(blink, LED_RED);
            end else if (powerup_busy) begin
                // Still powering up, blinking green
                module_health_indicator <= ndio_flash(blink, LED_GRN);
            end else begin
                // Running normally, solid green
                module_health_indicator <= LED_GRN;
            end
            if (ack_dup_fail) begin
                // Acknowledge or duplicate id failure, solid red
                network_health_indicator <= LED_RED;
            end else if (!id_valid) begin
                // Rotary id out of range, blinking red
                network_health_indicator <= ndio_flash(blink, LED_RED);
            end else if (life_err_ff) begin
                // Communication loss latched in life error, blinking green until cleared
                network_health_indicator <= ndio_flash(blink, LED_GRN);
            end else begin
                // Link healthy, solid green
                network_health_indicator <= LED_GRN;
            end
        end
    end
endmodule // ndio_image

// file: ndio_image_sva.sv
// Port checker for the discrete I/O image block
`timescale 1ns/1ps
module ndio_image_sva #(
    parameter integer NPTS = 8
) (
    input logic clk,
    input logic sys_rst,
    input logic con_valid,
    input logic ctrl_stopped,
    input logic comm_lost,
    input logic solid_state,
    input logic [119:0] con_image,
    input logic [NPTS-1:0] raw_inputs,
    input logic [NPTS-1:0] out_fault,
    input logic [NPTS-1:0] dout_ff,
    input logic [NPTS-1:0] in_led,
    input logic [7:0] node_id,
    input logic [63:0] pro_image_ff,
    input logic pro_send_ff,
    input logic pro_broadcast,
    input logic id_valid,
    input logic [31:0] baud_rate
);
    // Controller running: neither stopped nor cut off
    wire run = !ctrl_stopped && !comm_lost;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_out_follow: assert property (con_valid && run ##1 (!con_valid && run)[*3] |->
        dout_ff == $past(con_image[7:0], 3)) else $error("output late");
    a_in_image: assert property (!$past(sys_rst) |->
        pro_image_ff[7:0] == $past(in_led)) else $error("input image");
    a_fault_lo: assert property (!$past(sys_rst) |->
        pro_image_ff[8] == $past(solid_state && |out_fault[3:0])) else $error("fault lo");
    a_fault_hi: assert property (!$past(sys_rst) |->
        pro_image_ff[9] == $past(solid_state && |out_fault[7:4])) else $error("fault hi");
    a_id_range: assert property (id_valid == (node_id inside {[8'h01:8'hFD]}))
        else $error("id range");
    a_fixed_rate: assert property (baud_rate == 32'h0001E848 && pro_broadcast)
        else $error("rate");
    a_send_change: assert property (!$past(sys_rst) && $changed(raw_inputs) |=>
        pro_send_ff) else $error("no send");
    a_life_set: assert property (comm_lost |-> ##[1:3] pro_image_ff[41])
        else $error("life flag");
    a_resv_zero: assert property (pro_image_ff[31:10] == 22'h000000)
        else $error("reserved bits");
    cover property (con_valid && run);
    cover property (comm_lost ##1 !comm_lost);
    cover property (ctrl_stopped);
    cover property (pro_send_ff);
endmodule // ndio_image_sva
bind ndio_image ndio_image_sva #(.NPTS(NPTS)) ndio_image_sva_inst (.clk, .sys_rst,
    .con_valid, .ctrl_stopped, .comm_lost, .solid_state, .con_image, .raw_inputs,
    .out_fault, .dout_ff, .in_led, .node_id, .pro_image_ff, .pro_send_ff, .pro_broadcast,
    .id_valid, .baud_rate);

// file: ndio_regs.vh
// Constants for the networked discrete I/O image block
`ifndef NDIO_REGS_VH
`define NDIO_REGS_VH
// Consumed image (0-based bit index = printed position - 1)
`define NDIO_CON_WIDTH 120
`define NDIO_CON_OUT_LSB 0
`define NDIO_CON_HOLD_LSB 64
`define NDIO_CON_POL_BIT 79
`define NDIO_CON_OVR_LSB 96
// Produced image
`define NDIO_PRO_WIDTH 64
`define NDIO_PRO_IN_LSB 0
`define NDIO_PRO_FLT_LO_BIT 8
`define NDIO_PRO_FLT_HI_BIT 9
`define NDIO_PRO_DIAG_LSB 32
`define NDIO_PRO_FW_LSB 48
`define NDIO_PRO_CLASS_LSB 56
// Diagnosis word bits
`define NDIO_DIAG_LIFE_BIT 9
`define NDIO_DIAG_PUP_BIT 10
// Node id limits
`define NDIO_ID_MIN 8'h01
`define NDIO_ID_MAX 8'hFD
// Timing
`define NDIO_CLK_HZ 250000000
`define NDIO_BAUD 125000
`define NDIO_BLINK_MS 250
`endif

// file: tb_top.sv
// Self-checking bench for the discrete I/O image block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic sys_rst, con_valid, ctrl_stopped, comm_lost, diag_clear, solid_state, id_valid, pol;
    logic mem_test_fail, io_test_fail, powerup_busy, ack_dup_fail;
    logic [119:0] con_image, img;
    logic [7:0] raw_inputs, out_fault, node_id, dout_ff, out_led, in_led, pout, hold, ovr;
    logic [3:0] seen_m, seen_n;
    logic [63:0] pro_image_ff;
    logic [1:0] module_health_indicator, network_health_indicator;
    integer seed = 32'h492680CC, n_fail = 0, n_tests = 0, i;
    ndio_ctrl_model ndio_ctrl_model_inst (.clk, .con_image, .con_valid, .ctrl_stopped,
        .comm_lost, .diag_clear);
    ndio_image #(.BLINK_HALF(4)) ndio_image_inst (.clk, .sys_rst, .con_image, .con_valid,
        .ctrl_stopped, .comm_lost, .diag_clear, .raw_inputs, .out_fault, .solid_state,
        .node_id, .mem_test_fail, .io_test_fail, .powerup_busy, .ack_dup_fail, .dout_ff,
        .pro_image_ff, .pro_send_ff(), .pro_broadcast(), .id_valid, .baud_rate(),
        .module_health_indicator, .network_health_indicator, .in_led, .out_led);
    initial forever #2 clk = ~clk;
    // Counted compare
    task chk(input logic [63:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Low produced word: flags and adjusted inputs
    function automatic logic [31:0] lo(input logic [7:0] r, f, input logic s, p);
        return {22'h0, s & |f[7:4], s & |f[3:0], r ^ {8{p}}};
    endfunction
    // Gather indicator codes seen over one blink period
    task watch(output logic [3:0] m, n);
        {m, n} = 8'h00;
        repeat (8) begin
            @(negedge clk);
            m[module_health_indicator] = 1'b1;
            n[network_health_indicator] = 1'b1;
        end
    endtask
    task results;
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results;
    end
    initial begin
        {raw_inputs, out_fault, solid_state, node_id} = 25'h0;
        {mem_test_fail, io_test_fail, powerup_busy, ack_dup_fail, sys_rst} = 5'h1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        chk(pro_image_ff[42], 1'b1);
        for (i = 0; i < 40; i++) begin
            {pout, hold, ovr, pol} = 25'($random(seed));
            // All-hold and all-override corners first
            if (i < 2) hold = {8{i[0]}};
            img = {$random(seed), $random(seed), $random(seed), 24'($random(seed))};
            {img[103:96], img[79], img[71:64], img[7:0]} = {ovr, pol, hold, pout};
            ndio_ctrl_model_inst.send(img);
            repeat (3) @(negedge clk);
            chk({out_led, dout_ff}, {2{pout}});
            node_id = i < 4 ? 8'hFD + 8'(i) : 8'($random(seed));
            {raw_inputs, out_fault, solid_state} = 17'($random(seed));
            repeat (2) @(negedge clk);
            chk(pro_image_ff[31:0], lo(raw_inputs, out_fault, solid_state, pol));
            chk(id_valid, node_id inside {[8'h01:8'hFD]});
            chk(in_led, raw_inputs ^ {8{pol}});
            // Odd passes lose the link, even passes stop
            ndio_ctrl_model_inst.state({!i[0], i[0], 1'b0});
            repeat (8) @(negedge clk);
            chk(dout_ff, pout & hold | ovr & ~hold);
            chk(pro_image_ff[41], i[0]);
            ndio_ctrl_model_inst.state(3'h1);
            ndio_ctrl_model_inst.state(3'h0);
            repeat (2) @(negedge clk);
            chk(pro_image_ff[42:41], 2'h0);
        end
        node_id = 8'h01;
        repeat (2) @(negedge clk);
        chk({module_health_indicator, network_health_indicator}, 4'h5);
        {mem_test_fail, ack_dup_fail} = 2'h3;
        repeat (2) @(negedge clk);
        chk({module_health_indicator, network_health_indicator}, 4'hA);
        // Blinking states: failed I/O test and bad id, then power-up and lost link
        {mem_test_fail, ack_dup_fail, io_test_fail, powerup_busy} = 4'h3;
        node_id = 8'h00;
        ndio_ctrl_model_inst.state(3'h2);
        repeat (2) @(negedge clk);
        watch(seen_m, seen_n);
        chk(seen_m, 4'h5);
        chk(seen_n, 4'h5);
        {io_test_fail, node_id} = 9'h001;
        repeat (2) @(negedge clk);
        watch(seen_m, seen_n);
        chk(seen_m, 4'h3);
        chk(seen_n, 4'h3);
        results;
    end
endmodule // tb_top
